//--- rch_pkg.sv
// constants shared by the remote command handler
package rch_pkg;
    // ==========================================
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CMD = 8'h04;
    localparam logic [7:0] OFF_TGT0 = 8'h08;
    localparam logic [7:0] OFF_TGT1 = 8'h0c;
    localparam logic [7:0] OFF_SPEED = 8'h10;
    localparam logic [7:0] OFF_STEP = 8'h14;
    localparam logic [7:0] OFF_PCT = 8'h18;
    localparam logic [7:0] OFF_IMIN = 8'h1c;
    localparam logic [7:0] OFF_IMAX = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h24;
    localparam logic [7:0] OFF_EFF0 = 8'h28;
    localparam logic [7:0] OFF_EFF1 = 8'h2c;
    localparam logic [7:0] OFF_CUR = 8'h30;
    localparam logic [7:0] OFF_NODE = 8'h34;
    // ==========================================
    // field positions
    localparam int CTRL_SIM_EN = 0;
    localparam int CTRL_SEL_B = 1;
    localparam int CMD_CTL_SEL = 4;
    localparam int ST_REMOTE = 0;
    localparam int ST_ACTIVE = 1;
    localparam int ST_ONLINE = 2;
    localparam int ST_SOL_ON = 3;
    localparam int ST_SEL_B = 4;
    localparam int ST_REJECT = 5;
    localparam int ST_NO_BUS = 6;
    localparam int ST_FB_PRES = 7;
    // ==========================================
    // command opcodes
    localparam logic [3:0] OP_STEP_UP = 4'h1;
    localparam logic [3:0] OP_STEP_DN = 4'h2;
    localparam logic [3:0] OP_START = 4'h3;
    localparam logic [3:0] OP_STOP = 4'h4;
    localparam logic [3:0] OP_TO_REMOTE = 4'h5;
    localparam logic [3:0] OP_TO_LOCAL = 4'h6;
    localparam logic [3:0] OP_ENABLE = 4'h7;
    localparam logic [3:0] OP_DISABLE = 4'h8;
    localparam logic [3:0] OP_FB_QUERY = 4'h9;
    // ==========================================
    // limits, reset values and timing
    localparam logic [10:0] SPEED_MAX = 11'd2000;
    localparam logic [6:0] PCT_MAX = 7'd100;
    localparam logic [15:0] IMIN_RST = 16'h0000;
    localparam logic [15:0] IMAX_RST = 16'h0000;
    localparam logic [15:0] VAL_MAX = 16'hffff;
    localparam int CLK_PERIOD_NS = 5;
    localparam int RAMP_PERIOD_NS = 1000;
    localparam int RAMP_CYC = RAMP_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [7:0] RAMP_LAST = 8'(RAMP_CYC - 1);
    // ==========================================
    // types
    typedef enum logic {RCH_LOCAL, RCH_REMOTE} rch_mode_t;
    typedef enum logic {RCH_DISABLED, RCH_ACTIVE} rch_state_t;
    typedef struct packed {
        logic on_s1;
        logic on_s2;
        logic fb_s1;
        logic fb_s2;
        logic [7:0] bs_s1;
        logic [7:0] bs_s2;
        rch_mode_t mode;
        rch_state_t state;
        logic sim_en;
        logic sel_b;
        logic [15:0] tgt0;
        logic [15:0] tgt1;
        logic [15:0] eff0;
        logic [15:0] eff1;
        logic [10:0] speed;
        logic [15:0] step;
        logic [6:0] pct;
        logic [15:0] imin;
        logic [15:0] imax;
        logic sol_on;
        logic [15:0] sol_a;
        logic [15:0] sol_b;
        logic reject;
        logic no_bus;
        logic [7:0] bus_state;
        logic [7:0] node;
        logic [7:0] tick;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } rch_regs_t;
endpackage

//--- rch_handler.sv
// remote command handler: apb register file, command checks, ramp and solenoid drive
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - command value taken only online in remote
// - simulation off keeps last command value
// - linear ramp to new value, speed 0..2000
// - step up adds, step down subtracts step
// - separate simulated settings per two controllers
// - valve actuation only online in remote mode
// - current percent maps linearly imin to imax
// - start drives selected solenoid, stop removes current
// - selection routes current to solenoid a/b
// - mode switch only online and state disabled
// - to remote only from local mode
// - to local only from remote, stops valve
// - enable online in remote sets active
// - disable online in remote sets disabled
// - fieldbus query reports absent port or states
module rch_handler (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic link_online_in,
    input wire logic fieldbus_present_in,
    input wire logic [7:0] bus_state_in,
    output logic remote_host_mode_out,
    output logic module_active_out,
    output logic [15:0] cmd_eff0_out,
    output logic [15:0] cmd_eff1_out,
    output logic [15:0] sol_a_current_out,
    output logic [15:0] sol_b_current_out,
    output logic reject_out
);
    rch_pkg::rch_regs_t s_r;
    rch_pkg::rch_regs_t s_nxt;

    // ==========================================
    // ramp helper
    function automatic logic [15:0] ramp_step(input logic [15:0] eff, input logic [15:0] tgt,
                                              input logic [10:0] spd);
        logic [15:0] d;
        d = 16'h0000;
        if (spd == 11'd0) begin
            ramp_step = tgt;
        end else if (eff < tgt) begin
            d = tgt - eff;
            ramp_step = (d > {5'h00, spd}) ? eff + {5'h00, spd} : tgt;
        end else begin
            d = eff - tgt;
            ramp_step = (d > {5'h00, spd}) ? eff - {5'h00, spd} : tgt;
        end
    endfunction

    function automatic logic [15:0] add_sat(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        add_sat = sum[16] ? rch_pkg::VAL_MAX : sum[15:0];
    endfunction

    // ==========================================
    // next state
    always_comb begin
        logic ok_rem;
        logic ok_sw;
        logic acc;
        logic wr;
        logic set_rej;
        logic set_nobus;
        logic clr_rej;
        logic clr_nobus;
        logic [15:0] span;
        logic [22:0] prod;
        logic [15:0] cur;
        logic [15:0] tsel;
        logic [3:0] op;
        logic csel;
        logic mapped;
        logic [31:0] rd;
        ok_rem = 1'b0;
        ok_sw = 1'b0;
        acc = 1'b0;
        wr = 1'b0;
        set_rej = 1'b0;
        set_nobus = 1'b0;
        clr_rej = 1'b0;
        clr_nobus = 1'b0;
        span = 16'h0000;
        prod = 23'h000000;
        cur = 16'h0000;
        tsel = 16'h0000;
        op = pwdata_in[3:0];
        csel = pwdata_in[rch_pkg::CMD_CTL_SEL];
        mapped = 1'b1;
        rd = 32'h00000000;
        s_nxt = s_r;

        // input synchronisers
        s_nxt.on_s1 = link_online_in;
        s_nxt.on_s2 = s_r.on_s1;
        s_nxt.fb_s1 = fieldbus_present_in;
        s_nxt.fb_s2 = s_r.fb_s1;
        s_nxt.bs_s1 = bus_state_in;
        s_nxt.bs_s2 = s_r.bs_s1;

        ok_rem = s_r.on_s2 && (s_r.mode == rch_pkg::RCH_REMOTE);
        ok_sw = s_r.on_s2 && (s_r.state == rch_pkg::RCH_DISABLED);

        // apb: one wait-free access cycle after setup
        s_nxt.pready = psel_in && !penable_in && !s_r.pready;
        acc = psel_in && penable_in && s_r.pready;
        wr = acc && pwrite_in;

        // read data and decode, captured in setup
        case (paddr_in)
            rch_pkg::OFF_CTRL: rd = {30'h0, s_r.sel_b, s_r.sim_en};
            rch_pkg::OFF_CMD: rd = 32'h00000000;
            rch_pkg::OFF_TGT0: rd = {16'h0, s_r.tgt0};
            rch_pkg::OFF_TGT1: rd = {16'h0, s_r.tgt1};
            rch_pkg::OFF_SPEED: rd = {21'h0, s_r.speed};
            rch_pkg::OFF_STEP: rd = {16'h0, s_r.step};
            rch_pkg::OFF_PCT: rd = {25'h0, s_r.pct};
            rch_pkg::OFF_IMIN: rd = {16'h0, s_r.imin};
            rch_pkg::OFF_IMAX: rd = {16'h0, s_r.imax};
            rch_pkg::OFF_STATUS: rd = {16'h0, s_r.bus_state, s_r.fb_s2, s_r.no_bus, s_r.reject,
                                       s_r.sel_b, s_r.sol_on, s_r.on_s2,
                                       s_r.state == rch_pkg::RCH_ACTIVE,
                                       s_r.mode == rch_pkg::RCH_REMOTE};
            rch_pkg::OFF_EFF0: rd = {16'h0, s_r.eff0};
            rch_pkg::OFF_EFF1: rd = {16'h0, s_r.eff1};
            rch_pkg::OFF_CUR: rd = {16'h0, s_r.sol_a | s_r.sol_b};
            rch_pkg::OFF_NODE: rd = {24'h0, s_r.fb_s2 ? s_r.node : 8'h00};
            default: mapped = 1'b0;
        endcase
        if (psel_in && !penable_in) begin
            s_nxt.prdata = pwrite_in ? 32'h00000000 : rd;
            s_nxt.pslverr = !mapped;
        end

        // register writes and commands
        if (wr && mapped) begin
            case (paddr_in)
                rch_pkg::OFF_CTRL: begin
                    if (ok_rem) begin
                        s_nxt.sim_en = pwdata_in[rch_pkg::CTRL_SIM_EN];
                        s_nxt.sel_b = pwdata_in[rch_pkg::CTRL_SEL_B];
                    end else begin
                        set_rej = 1'b1;
                    end
                end
                rch_pkg::OFF_TGT0: begin
                    if (ok_rem) begin
                        s_nxt.tgt0 = pwdata_in[15:0];
                    end else begin
                        set_rej = 1'b1;
                    end
                end
                rch_pkg::OFF_TGT1: begin
                    if (ok_rem) begin
                        s_nxt.tgt1 = pwdata_in[15:0];
                    end else begin
                        set_rej = 1'b1;
                    end
                end
                rch_pkg::OFF_SPEED: begin
                    s_nxt.speed = (pwdata_in[31:0] > {21'h0, rch_pkg::SPEED_MAX}) ?
                                  rch_pkg::SPEED_MAX : pwdata_in[10:0];
                end
                rch_pkg::OFF_STEP: s_nxt.step = pwdata_in[15:0];
                rch_pkg::OFF_PCT: begin
                    if (ok_rem) begin
                        s_nxt.pct = (pwdata_in[31:0] > {25'h0, rch_pkg::PCT_MAX}) ?
                                    rch_pkg::PCT_MAX : pwdata_in[6:0];
                    end else begin
                        set_rej = 1'b1;
                    end
                end
                rch_pkg::OFF_IMIN: s_nxt.imin = pwdata_in[15:0];
                rch_pkg::OFF_IMAX: s_nxt.imax = pwdata_in[15:0];
                rch_pkg::OFF_NODE: s_nxt.node = pwdata_in[7:0];
                rch_pkg::OFF_STATUS: begin
                    clr_rej = pwdata_in[rch_pkg::ST_REJECT];
                    clr_nobus = pwdata_in[rch_pkg::ST_NO_BUS];
                end
                rch_pkg::OFF_CMD: begin
                    tsel = csel ? s_r.tgt1 : s_r.tgt0;
                    case (op)
                        rch_pkg::OP_STEP_UP, rch_pkg::OP_STEP_DN: begin
                            if (ok_rem) begin
                                if (op == rch_pkg::OP_STEP_UP) begin
                                    tsel = add_sat(tsel, s_r.step);
                                end else begin
                                    tsel = (tsel > s_r.step) ? tsel - s_r.step : 16'h0000;
                                end
                                if (csel) begin
                                    s_nxt.tgt1 = tsel;
                                end else begin
                                    s_nxt.tgt0 = tsel;
                                end
                            end else begin
                                set_rej = 1'b1;
                            end
                        end
                        rch_pkg::OP_START, rch_pkg::OP_STOP: begin
                            if (ok_rem) begin
                                s_nxt.sol_on = (op == rch_pkg::OP_START);
                            end else begin
                                set_rej = 1'b1;
                            end
                        end
                        rch_pkg::OP_TO_REMOTE: begin
                            if (ok_sw && s_r.mode == rch_pkg::RCH_LOCAL) begin
                                s_nxt.mode = rch_pkg::RCH_REMOTE;
                            end else begin
                                set_rej = 1'b1;
                            end
                        end
                        rch_pkg::OP_TO_LOCAL: begin
                            if (ok_sw && s_r.mode == rch_pkg::RCH_REMOTE) begin
                                s_nxt.mode = rch_pkg::RCH_LOCAL;
                                s_nxt.sol_on = 1'b0;
                            end else begin
                                set_rej = 1'b1;
                            end
                        end
                        rch_pkg::OP_ENABLE, rch_pkg::OP_DISABLE: begin
                            if (ok_rem) begin
                                s_nxt.state = (op == rch_pkg::OP_ENABLE) ?
                                    rch_pkg::RCH_ACTIVE :
                                    rch_pkg::RCH_DISABLED;
                            end else begin
                                set_rej = 1'b1;
                            end
                        end
                        rch_pkg::OP_FB_QUERY: begin
                            if (s_r.fb_s2) begin
                                s_nxt.bus_state = s_r.bs_s2;
                            end else begin
                                set_nobus = 1'b1;
                                s_nxt.bus_state = 8'h00;
                            end
                        end
                        default: set_rej = 1'b1;
                    endcase
                end
                default: ;
            endcase
        end

        // sticky flags, set beats clear
        s_nxt.reject = (s_r.reject && !clr_rej) || set_rej;
        s_nxt.no_bus = (s_r.no_bus && !clr_nobus) || set_nobus;

        // ramp of effective commands, held while simulation is off
        if (s_r.tick == rch_pkg::RAMP_LAST) begin
            s_nxt.tick = 8'h00;
        end else begin
            s_nxt.tick = s_r.tick + 8'h01;
        end
        if (s_r.sim_en && s_r.tick == rch_pkg::RAMP_LAST) begin
            s_nxt.eff0 = ramp_step(s_r.eff0, s_r.tgt0, s_r.speed);
            s_nxt.eff1 = ramp_step(s_r.eff1, s_r.tgt1, s_r.speed);
        end

        // solenoid current from percentage
        span = (s_r.imax > s_r.imin) ? s_r.imax - s_r.imin : 16'h0000;
        prod = 23'({7'h00, span} * {16'h0000, s_r.pct});
        cur = s_r.imin + 16'(prod / 23'd100);
        s_nxt.sol_a = (s_r.sol_on && !s_r.sel_b) ? cur : 16'h0000;
        s_nxt.sol_b = (s_r.sol_on && s_r.sel_b) ? cur : 16'h0000;
    end

    // ==========================================
    // state register
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            s_r <= '0;
            s_r.mode <= rch_pkg::RCH_LOCAL;
            s_r.state <= rch_pkg::RCH_DISABLED;
            s_r.imin <= rch_pkg::IMIN_RST;
            s_r.imax <= rch_pkg::IMAX_RST;
        end else if (clk_en_in) begin
            s_r <= s_nxt;
        end
    end

    // ==========================================
    // outputs
    assign prdata_out = s_r.prdata;
    assign pready_out = s_r.pready;
    assign pslverr_out = s_r.pslverr;
    assign remote_host_mode_out = (s_r.mode == rch_pkg::RCH_REMOTE);
    assign module_active_out = (s_r.state == rch_pkg::RCH_ACTIVE);
    assign cmd_eff0_out = s_r.eff0;
    assign cmd_eff1_out = s_r.eff1;
    assign sol_a_current_out = s_r.sol_a;
    assign sol_b_current_out = s_r.sol_b;
    assign reject_out = s_r.reject;
endmodule // rch_handler
`default_nettype wire

//--- rch_handler_sva.sv
// port assertions for the remote command handler
`timescale 1ns/1ps
`default_nettype none
module rch_handler_sva (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic link_online_in,
    input wire logic fieldbus_present_in,
    input wire logic [7:0] bus_state_in,
    input wire logic remote_host_mode_out,
    input wire logic module_active_out,
    input wire logic [15:0] cmd_eff0_out,
    input wire logic [15:0] cmd_eff1_out,
    input wire logic [15:0] sol_a_current_out,
    input wire logic [15:0] sol_b_current_out,
    input wire logic reject_out
);
    logic [7:0] gap_r;
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);
    // ==========
    // cycles since the effective command last moved
    always_ff @(posedge clock_in) begin
        if (reset_in || cmd_eff0_out != $past(cmd_eff0_out)) begin
            gap_r <= 8'h00;
        end else if (gap_r != 8'hff) begin
            gap_r <= gap_r + 8'h01;
        end
    end
    // ==========
    // properties
    AST_READY_AFTER_SETUP: assert property (
        psel_in && !penable_in && clk_en_in |=> pready_out) else $error("no ready after setup");
    AST_READY_PULSE: assert property (
        pready_out && clk_en_in |=> !pready_out) else $error("ready longer than one cycle");
    AST_SLVERR_WITH_READY: assert property (
        $rose(pslverr_out) |-> pready_out) else $error("slave error without ready");
    AST_MODE_BY_CMD: assert property (
        remote_host_mode_out != $past(remote_host_mode_out)
        |-> $past(psel_in && penable_in && pwrite_in && paddr_in == rch_pkg::OFF_CMD))
        else $error("mode changed without a command write");
    AST_MODE_DISABLED: assert property (
        remote_host_mode_out != $past(remote_host_mode_out) |-> !module_active_out)
        else $error("mode changed while active");
    AST_ACTIVE_REMOTE: assert property (
        module_active_out |-> remote_host_mode_out) else $error("active outside remote mode");
    AST_STATE_BY_CMD: assert property (
        module_active_out != $past(module_active_out)
        |-> remote_host_mode_out && $past(pwrite_in && paddr_in == rch_pkg::OFF_CMD))
        else $error("state changed without a remote command");
    AST_LOCAL_NO_CURRENT: assert property (
        !remote_host_mode_out [*2] |-> sol_a_current_out == 16'h0000
        && sol_b_current_out == 16'h0000) else $error("current in local mode");
    AST_ONE_SOLENOID: assert property (
        !(sol_a_current_out != 16'h0000 && sol_b_current_out != 16'h0000))
        else $error("both solenoids driven");
    AST_REJECT_STICKY: assert property (
        reject_out && !(psel_in && pwrite_in && paddr_in == rch_pkg::OFF_STATUS)
        |=> reject_out) else $error("reject flag lost");
    AST_RAMP_PACE: assert property (
        cmd_eff0_out != $past(cmd_eff0_out) |-> gap_r >= 8'd150)
        else $error("effective command moved off the ramp tick");
endmodule // rch_handler_sva
bind rch_handler rch_handler_sva u_sva (.clock_in(clock_in), .reset_in(reset_in),
    .clk_en_in(clk_en_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .link_online_in(link_online_in),
    .fieldbus_present_in(fieldbus_present_in), .bus_state_in(bus_state_in),
    .remote_host_mode_out(remote_host_mode_out), .module_active_out(module_active_out),
    .cmd_eff0_out(cmd_eff0_out), .cmd_eff1_out(cmd_eff1_out),
    .sol_a_current_out(sol_a_current_out), .sol_b_current_out(sol_b_current_out),
    .reject_out(reject_out));
`default_nettype wire

//--- rch_host_link.sv
// host link and fieldbus side model
`timescale 1ns/1ps
`default_nettype none
module rch_host_link #(
    parameter int LINK_DELAY = 4
) (
    input wire logic clock_in,
    input wire logic online_req_in,
    input wire logic bus_fitted_in,
    input wire logic [7:0] bus_word_in,
    output logic link_online_out,
    output logic fieldbus_present_out,
    output logic [7:0] bus_state_out
);
    logic [7:0] wait_r = 8'h00;
    logic up_r = 1'b0;
    logic fit_r = 1'b0;
    logic [7:0] pat_r = 8'h5a;
    logic [7:0] word_r = 8'h00;
    assign link_online_out = up_r;
    assign fieldbus_present_out = fit_r;
    assign bus_state_out = fit_r ? word_r : pat_r;
    // ==========
    // link comes up late, drops at once
    always_ff @(posedge clock_in) begin
        if (!online_req_in) begin
            wait_r <= 8'h00;
            up_r <= 1'b0;
        end else if (wait_r >= 8'(LINK_DELAY)) begin
            up_r <= 1'b1;
        end else begin
            wait_r <= wait_r + 8'h01;
        end
    end
    // ==========
    // unfitted bus lines toggle every cycle
    always_ff @(posedge clock_in) begin
        fit_r <= bus_fitted_in;
        word_r <= bus_word_in;
        pat_r <= ~pat_r;
    end
endmodule // rch_host_link
`default_nettype wire

//--- rch_handler_bench.sv
// self-checking bench for the remote command handler
`timescale 1ns/1ps
`default_nettype none
module rch_handler_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pw = 1'b0;
    logic [7:0] pa = 8'h00;
    logic [31:0] pd = 32'h0;
    logic on_req = 1'b0;
    logic fit = 1'b0;
    logic [7:0] bw = 8'ha5;
    logic [31:0] prd, rdata;
    logic prdy, perr, lerr, online, fbp, mode, act, rej;
    logic [7:0] bst;
    logic [15:0] e0, e1, sa, sb;
    integer fails = 0;
    integer check_count = 0;
    initial begin
        forever #2.5 clk = ~clk;
    end
    rch_host_link u_link (.clock_in(clk), .online_req_in(on_req), .bus_fitted_in(fit),
        .bus_word_in(bw), .link_online_out(online), .fieldbus_present_out(fbp),
        .bus_state_out(bst));
    rch_handler u_dut (.clock_in(clk), .reset_in(rst), .clk_en_in(1'b1), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pw), .paddr_in(pa), .pwdata_in(pd), .prdata_out(prd),
        .pready_out(prdy), .pslverr_out(perr), .link_online_in(online),
        .fieldbus_present_in(fbp), .bus_state_in(bst), .remote_host_mode_out(mode),
        .module_active_out(act), .cmd_eff0_out(e0), .cmd_eff1_out(e1),
        .sol_a_current_out(sa), .sol_b_current_out(sb), .reject_out(rej));
    // ==========
    // helpers
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer n;
        psel <= 1'b1;
        pw <= w;
        pa <= a;
        pd <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'b1 && n < 20);
        if (prdy !== 1'b1) begin
            fails++;
            close_out();
        end else begin
            rdata = prd;
            lerr = perr;
            psel <= 1'b0;
            pen <= 1'b0;
            @(posedge clk);
        end
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, rdata, e);
    endtask
    task automatic cmd(input logic [3:0] op, input logic ctl);
        apb(1'b1, rch_pkg::OFF_CMD, {27'h0, ctl, op});
    endtask
    task automatic st(input logic m, input logic a, input logic r);
        repeat (3) @(posedge clk);
        chk("mode", {31'h0, mode}, {31'h0, m});
        chk("active", {31'h0, act}, {31'h0, a});
        chk("reject", {31'h0, rej}, {31'h0, r});
        apb(1'b1, rch_pkg::OFF_STATUS, 32'h60);
    endtask
    task automatic sol(input logic [15:0] a, input logic [15:0] b);
        repeat (3) @(posedge clk);
        chk("sol a", {16'h0, sa}, {16'h0, a});
        chk("sol b", {16'h0, sb}, {16'h0, b});
    endtask
    task automatic eff(input logic [15:0] a, input logic [15:0] b);
        repeat (1200) @(posedge clk);
        chk("eff0", {16'h0, e0}, {16'h0, a});
        chk("eff1", {16'h0, e1}, {16'h0, b});
    endtask
    // ==========
    // scenarios
    task automatic t_offline();
        rd("status", rch_pkg::OFF_STATUS, 32'h0);
        rd("unmapped", 8'h38, 32'h0);
        chk("slverr", {31'h0, lerr}, 32'h1);
        apb(1'b1, rch_pkg::OFF_TGT0, 32'h1234);
        rd("tgt offline", rch_pkg::OFF_TGT0, 32'h0);
        cmd(rch_pkg::OP_TO_REMOTE, 1'b0);
        st(1'b0, 1'b0, 1'b1);
        $display("test offline done");
    endtask
    task automatic t_mode();
        integer n;
        on_req <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (online !== 1'b1 && n < 30);
        chk("online", {31'h0, online}, 32'h1);
        repeat (3) @(posedge clk);
        cmd(rch_pkg::OP_TO_LOCAL, 1'b0);
        st(1'b0, 1'b0, 1'b1);
        cmd(rch_pkg::OP_ENABLE, 1'b0);
        st(1'b0, 1'b0, 1'b1);
        cmd(rch_pkg::OP_TO_REMOTE, 1'b0);
        st(1'b1, 1'b0, 1'b0);
        cmd(rch_pkg::OP_TO_REMOTE, 1'b0);
        st(1'b1, 1'b0, 1'b1);
        cmd(rch_pkg::OP_ENABLE, 1'b0);
        st(1'b1, 1'b1, 1'b0);
        cmd(rch_pkg::OP_TO_LOCAL, 1'b0);
        st(1'b1, 1'b1, 1'b1);
        cmd(rch_pkg::OP_DISABLE, 1'b0);
        st(1'b1, 1'b0, 1'b0);
        cmd(4'hf, 1'b0);
        st(1'b1, 1'b0, 1'b1);
        $display("test mode done");
    endtask
    task automatic t_current();
        apb(1'b1, rch_pkg::OFF_IMIN, 32'h64);
        apb(1'b1, rch_pkg::OFF_IMAX, 32'h44c);
        apb(1'b1, rch_pkg::OFF_PCT, 32'h32);
        cmd(rch_pkg::OP_START, 1'b0);
        sol(16'h258, 16'h0);
        apb(1'b1, rch_pkg::OFF_CTRL, 32'h2);
        sol(16'h0, 16'h258);
        apb(1'b1, rch_pkg::OFF_PCT, 32'h96);
        rd("pct", rch_pkg::OFF_PCT, 32'h64);
        sol(16'h0, 16'h44c);
        cmd(rch_pkg::OP_STOP, 1'b0);
        sol(16'h0, 16'h0);
        apb(1'b1, rch_pkg::OFF_CTRL, 32'h0);
        cmd(rch_pkg::OP_START, 1'b0);
        sol(16'h44c, 16'h0);
        cmd(rch_pkg::OP_TO_LOCAL, 1'b0);
        sol(16'h0, 16'h0);
        cmd(rch_pkg::OP_START, 1'b0);
        st(1'b0, 1'b0, 1'b1);
        cmd(rch_pkg::OP_TO_REMOTE, 1'b0);
        sol(16'h0, 16'h0);
        $display("test current done");
    endtask
    task automatic t_ramp();
        apb(1'b1, rch_pkg::OFF_SPEED, 32'hffff);
        rd("speed", rch_pkg::OFF_SPEED, 32'h7d0);
        apb(1'b1, rch_pkg::OFF_SPEED, 32'ha);
        apb(1'b1, rch_pkg::OFF_STEP, 32'h5);
        apb(1'b1, rch_pkg::OFF_TGT0, 32'h32);
        apb(1'b1, rch_pkg::OFF_TGT1, 32'h7);
        apb(1'b1, rch_pkg::OFF_CTRL, 32'h1);
        eff(16'h32, 16'h7);
        apb(1'b1, rch_pkg::OFF_TGT0, 32'h5a);
        repeat (250) @(posedge clk);
        chk("slope", {31'h0, e0 == 16'h3c || e0 == 16'h46}, 32'h1);
        rd("tgt", rch_pkg::OFF_TGT0, 32'h5a);
        cmd(rch_pkg::OP_STEP_UP, 1'b0);
        cmd(rch_pkg::OP_STEP_DN, 1'b1);
        cmd(rch_pkg::OP_STEP_DN, 1'b1);
        eff(16'h5f, 16'h0);
        apb(1'b1, rch_pkg::OFF_CTRL, 32'h0);
        apb(1'b1, rch_pkg::OFF_TGT0, 32'h0);
        eff(16'h5f, 16'h0);
        $display("test ramp done");
    endtask
    task automatic t_fb();
        apb(1'b1, rch_pkg::OFF_NODE, 32'h12);
        rd("node absent", rch_pkg::OFF_NODE, 32'h0);
        cmd(rch_pkg::OP_FB_QUERY, 1'b0);
        rd("no bus", rch_pkg::OFF_STATUS, 32'h45);
        apb(1'b1, rch_pkg::OFF_STATUS, 32'h60);
        fit <= 1'b1;
        repeat (6) @(posedge clk);
        apb(1'b1, rch_pkg::OFF_NODE, 32'h12);
        cmd(rch_pkg::OP_FB_QUERY, 1'b0);
        rd("bus state", rch_pkg::OFF_STATUS, 32'ha585);
        rd("node", rch_pkg::OFF_NODE, 32'h12);
        $display("test fieldbus done");
    endtask
    // ==========
    // main sequence and watchdog
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_offline();
        t_mode();
        t_current();
        t_ramp();
        t_fb();
        close_out();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        close_out();
    end
endmodule // rch_handler_bench
`default_nettype wire
